// [bench/fsar_host.sv]
// Purpose: host model issuing register reads and writes
// Assumes: one-cycle strobes, read data settled one cycle after the strobe
// Notes: address lines are inverted once an access is over, and write data too after a write
`timescale 1ns/1ps
module fsar_host (
   // clock
   input wire logic clk,
   // register access
   output logic [7:0] reg_addr,
   output logic reg_wr,
   output logic reg_rd,
   output logic [7:0] reg_wdata,
   input wire logic [7:0] reg_rdata
);
   initial begin
      reg_addr = 8'h00;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_wdata = 8'h00;
   end
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      reg_addr <= ~a;
      @(negedge clk);
      d = reg_rdata;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= v;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
      reg_addr <= ~a;
      reg_wdata <= ~v;
   endtask
endmodule

// [bench/fsar_top_asserts.sv]
// Purpose: port-level checks of the fault and result registers
// Assumes: host reads spaced two cycles apart
// Notes: bound into the top module
`timescale 1ns/1ps
module fsar_top_asserts #(
   parameter logic [35:0] LDO_DELAY_CYCLES = 36'd20,
   parameter logic [35:0] WDOG_BASE_CYCLES = 36'd50
) (
   // clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // register access
   input wire logic [7:0] reg_addr,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_wdata,
   input wire logic [7:0] reg_rdata,
   // fault conditions
   input wire logic die_overtemp,
   input wire logic switch_overcurrent,
   input wire logic hiccup_state,
   // alert pin
   input wire logic fault_alert_i,
   input wire logic fault_alert_o,
   input wire logic fault_alert_oe_n
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);
   sequence s_rd(a);
      reg_rd && reg_addr == a;
   endsequence
   sequence s_rel;
      reg_wr && reg_addr == fsar_pkg::REG_FAULT_P && reg_wdata[7];
   endsequence
   property p_hold(c, a, b);
      (c ##0 s_rd(a)) ##2 s_rd(a) |=> reg_rdata[b];
   endproperty
   a_status_alert: assert property (s_rd(fsar_pkg::REG_GEN_STATUS) |=> reg_rdata == {1'b0, $past(fault_alert_i), 6'h00})
      else $error("status byte does not show pin level");
   a_fp_rsvd: assert property (s_rd(fsar_pkg::REG_FAULT_P) |=> (reg_rdata & 8'he3) == 8'h00)
      else $error("primary fault byte has stray bits");
   a_fs_rsvd: assert property (s_rd(fsar_pkg::REG_FAULT_S) |=> !reg_rdata[0])
      else $error("secondary fault bit 0 set");
   a_lo_rsvd: assert property (s_rd(fsar_pkg::REG_RES_LO) |=> reg_rdata[7:6] == 2'h0)
      else $error("low result top bits set");
   a_release_only: assert property ($rose(fault_alert_oe_n) |-> $past(reg_wr && reg_addr == fsar_pkg::REG_FAULT_P))
      else $error("alert released without a release write");
   a_keep_low: assert property ((die_overtemp && !fault_alert_oe_n) ##0 s_rel |=> !fault_alert_oe_n)
      else $error("alert released while fault present");
   a_therm_hold: assert property (p_hold(die_overtemp, fsar_pkg::REG_FAULT_P, fsar_pkg::FP_THERM_BIT))
      else $error("thermal flag cleared while present");
   a_therm_clear: assert property ((!die_overtemp throughout (s_rd(fsar_pkg::REG_FAULT_P) ##2 s_rd(fsar_pkg::REG_FAULT_P))) |=> !reg_rdata[3])
      else $error("thermal flag not cleared by read");
   a_swoc_hold: assert property (p_hold(switch_overcurrent, fsar_pkg::REG_FAULT_P, fsar_pkg::FP_SWOC_BIT))
      else $error("switch flag cleared while present");
   a_hiccup_hold: assert property (p_hold(hiccup_state, fsar_pkg::REG_FAULT_S, fsar_pkg::FS_HICCUP_BIT))
      else $error("hiccup flag cleared in hiccup");
   a_drive_low: assert property (!fault_alert_oe_n |-> !fault_alert_o)
      else $error("alert driven high while enabled");
endmodule
bind fsar_top fsar_top_asserts #(.LDO_DELAY_CYCLES(LDO_DELAY_CYCLES), .WDOG_BASE_CYCLES(WDOG_BASE_CYCLES)) i_chk (
   .clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
   .reg_rdata(reg_rdata), .die_overtemp(die_overtemp), .switch_overcurrent(switch_overcurrent),
   .hiccup_state(hiccup_state), .fault_alert_i(fault_alert_i), .fault_alert_o(fault_alert_o),
   .fault_alert_oe_n(fault_alert_oe_n));

// [bench/tb_top.sv]
// Purpose: self-checking bench for the fault and result registers
// Assumes: short hold-off and timer counts set by parameters
// Notes: alert wire has a pull-up
`timescale 1ns/1ps
module tb_top;
   logic clk;
   logic sys_rst = 1'b1;
   logic [9:0] c = 10'h000;
   logic pwr_on = 1'b1;
   logic [1:0] wd_sel = 2'h0;
   logic conv_valid = 1'b0;
   logic [2:0] conv_channel = 3'h0;
   logic [13:0] conv_value = 14'h0000;
   logic is14 = 1'b0;
   logic [2:0] sel_ch = 3'h0;
   logic [7:0] reg_addr, reg_wdata, reg_rdata;
   logic reg_wr, reg_rd, alert_o, alert_oe_n;
   wire logic alert_wire = alert_oe_n ? 1'b1 : alert_o;
   int n_errors = 0;
   int num_checks = 0;
   fsar_host i_host (.clk(clk), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
      .reg_rdata(reg_rdata));
   fsar_top #(.LDO_DELAY_CYCLES(36'd20), .WDOG_BASE_CYCLES(36'd50)) i_dut (.clk(clk), .sys_rst(sys_rst),
      .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .ldo_overcurrent(c[0]), .ldo_undervolt(c[1]), .die_overtemp(c[2]), .switch_overcurrent(c[3]),
      .hiccup_state(c[4]), .input_below_uv(c[5]), .output_above_ov(c[6]), .low_demand_off_state(c[7]),
      .input_above_ov(c[8]), .power_on_state(pwr_on), .bus_error_event(c[9]), .wdog_period_sel(wd_sel),
      .conv_valid(conv_valid), .conv_channel(conv_channel), .conv_value(conv_value), .conv_is_14bit(is14),
      .result_channel_select(sel_ch), .fault_alert_i(alert_wire), .fault_alert_o(alert_o),
      .fault_alert_oe_n(alert_oe_n));
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   task automatic report_and_stop;
      if (n_errors == 0 && num_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
      num_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("BAD %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic do_reset;
      @(posedge clk);
      sys_rst <= 1'b1;
      wd_sel <= 2'h0;
      repeat (5) @(posedge clk);
      sys_rst <= 1'b0;
   endtask
   task automatic t_reset;
      logic [7:0] d;
      for (int i = 4; i < 9; i++) begin
         i_host.rd(8'(i), d);
         chk("reset_val", d, 8'h00);
      end
      chk("reset_pin", 8'(alert_oe_n), 8'h01);
   endtask
   task automatic t_latch(input int ci, input logic [7:0] a, input logic [7:0] m);
      logic [7:0] d;
      @(posedge clk);
      c[ci] <= 1'b1;
      repeat (3) @(posedge clk);
      #1 chk("alert_on", 8'(alert_oe_n), 8'h00);
      i_host.wr(8'h05, 8'h80);
      i_host.wr(a, 8'h7f);
      @(negedge clk) chk("alert_held", 8'(alert_oe_n), 8'h00);
      i_host.rd(8'h02, d);
      chk("pin_low", d, 8'h00);
      i_host.rd(a, d);
      chk("held1", d, m);
      i_host.rd(a, d);
      chk("held2", d, m);
      @(posedge clk);
      c[ci] <= 1'b0;
      i_host.rd(a, d);
      chk("last", d, m);
      i_host.rd(a, d);
      chk("clear", d, 8'h00);
      i_host.wr(8'h05, 8'h80);
      @(negedge clk) chk("alert_free", 8'(alert_oe_n), 8'h01);
      i_host.rd(8'h02, d);
      chk("pin_high", d, 8'h40);
   endtask
   task automatic t_ldo;
      logic [7:0] d;
      @(posedge clk);
      c[0] <= 1'b1;
      @(posedge clk);
      c[0] <= 1'b0;
      i_host.rd(8'h05, d);
      chk("ldo_set", d, 8'h10);
      repeat (20) @(posedge clk);
      i_host.rd(8'h05, d);
      chk("ldo_hold", d, 8'h10);
      i_host.rd(8'h05, d);
      chk("ldo_clear", d, 8'h00);
      i_host.wr(8'h05, 8'h80);
   endtask
   task automatic t_buserr;
      logic [7:0] d;
      @(posedge clk);
      c[9] <= 1'b1;
      @(posedge clk);
      c[9] <= 1'b0;
      repeat (2) @(posedge clk);
      #1 chk("berr_alert", 8'(alert_oe_n), 8'h00);
      i_host.rd(8'h06, d);
      chk("berr_set", d, 8'h02);
      i_host.rd(8'h06, d);
      chk("berr_clear", d, 8'h00);
      i_host.wr(8'h05, 8'h80);
   endtask
   task automatic t_vinov;
      logic [7:0] d;
      @(posedge clk);
      pwr_on <= 1'b0;
      c[8] <= 1'b1;
      i_host.rd(8'h06, d);
      chk("input_overvolt_flag_off", d, 8'h00);
      @(posedge clk);
      c[8] <= 1'b0;
      pwr_on <= 1'b1;
   endtask
   task automatic t_res;
      logic [7:0] d;
      logic [13:0] v [2];
      v[0] = 14'h1e5b;
      v[1] = 14'h0a3c;
      @(posedge clk);
      conv_valid <= 1'b1;
      conv_channel <= 3'h3;
      conv_value <= v[0];
      @(posedge clk);
      conv_channel <= 3'h5;
      conv_value <= v[1];
      @(posedge clk);
      conv_valid <= 1'b0;
      for (int k = 0; k < 4; k++) begin
         @(posedge clk);
         sel_ch <= k[0] ? 3'h5 : 3'h3;
         is14 <= k[1];
         i_host.rd(8'h07, d);
         chk("res_hi", d, k[1] ? v[k[0]][13:6] : v[k[0]][7:0]);
         i_host.rd(8'h08, d);
         chk("res_lo", d, k[1] ? {2'h0, v[k[0]][5:0]} : 8'h00);
      end
   endtask
   task automatic t_wd(input logic [1:0] s, input int n, input logic [7:0] e);
      logic [7:0] d;
      @(posedge clk);
      wd_sel <= s;
      repeat (2) begin
         repeat (n) @(posedge clk);
         i_host.rd(8'h06, d);
         chk("wdog", d, e);
      end
      do_reset;
   endtask
   task automatic t_wd_off;
      logic [7:0] d;
      @(posedge clk);
      wd_sel <= 2'h1;
      repeat (40) @(posedge clk);
      wd_sel <= 2'h0;
      @(posedge clk);
      wd_sel <= 2'h1;
      repeat (40) @(posedge clk);
      i_host.rd(8'h06, d);
      chk("wdog_off", d, 8'h00);
      do_reset;
   endtask
   initial begin
      repeat (5) @(posedge clk);
      sys_rst <= 1'b0;
      t_reset;
      t_latch(1, 8'h05, 8'h10);
      t_latch(2, 8'h05, 8'h08);
      t_latch(3, 8'h05, 8'h04);
      t_latch(4, 8'h06, 8'h40);
      t_latch(5, 8'h06, 8'h20);
      t_latch(6, 8'h06, 8'h10);
      t_latch(7, 8'h06, 8'h08);
      t_latch(8, 8'h06, 8'h04);
      t_ldo;
      t_buserr;
      t_vinov;
      t_res;
      t_wd(2'h0, 300, 8'h00);
      t_wd(2'h1, 40, 8'h00);
      t_wd(2'h1, 60, 8'h80);
      t_wd(2'h2, 90, 8'h00);
      t_wd(2'h2, 110, 8'h80);
      t_wd(2'h3, 190, 8'h00);
      t_wd(2'h3, 210, 8'h80);
      t_wd_off;
      report_and_stop;
   end
   initial begin
      repeat (10000) @(posedge clk);
      n_errors++;
      report_and_stop;
   end
endmodule

// [core/fsar_ifs.sv]
// Purpose: carriers between the readout top and its helpers
// Assumes: single clock domain
// Notes: one carrier per helper
`timescale 1ns/1ps
interface fsar_tmr_if;
   logic run;
   logic kick;
   logic [35:0] limit;
   logic busy;
   logic done;
   modport ctl (output run, output kick, output limit, input busy, input done);
   modport tmr (input run, input kick, input limit, output busy, output done);
endinterface

interface fsar_res_if;
   logic wr;
   logic [2:0] wr_ch;
   logic [13:0] wr_val;
   logic [2:0] rd_ch;
   logic [13:0] rd_val;
   modport ctl (output wr, output wr_ch, output wr_val, output rd_ch, input rd_val);
   modport mem (input wr, input wr_ch, input wr_val, input rd_ch, output rd_val);
endinterface

// [core/fsar_pkg.sv]
// Purpose: shared constants for the fault status and result readout block
// Assumes: 50 MHz core clock, byte-wide register access port
// Notes: offsets are the register addresses seen on the access port
package fsar_pkg;
   // register offsets
   localparam logic [7:0] REG_GEN_STATUS = 8'h02;
   localparam logic [7:0] REG_FAULT_P = 8'h05;
   localparam logic [7:0] REG_FAULT_S = 8'h06;
   localparam logic [7:0] REG_RES_HI = 8'h07;
   localparam logic [7:0] REG_RES_LO = 8'h08;
   // general status fields
   localparam int GS_ALERT_BIT = 6;
   // primary fault fields
   localparam int FP_IRQ_RELEASE_BIT = 7;
   localparam int FP_LDO_BIT = 4;
   localparam int FP_THERM_BIT = 3;
   localparam int FP_SWOC_BIT = 2;
   // secondary fault fields
   localparam int FS_WDOG_BIT = 7;
   localparam int FS_HICCUP_BIT = 6;
   localparam int FS_VIN_UV_BIT = 5;
   localparam int FS_OUTPUT_OVERVOLT_FLAG_BIT = 4;
   localparam int FS_LOWDEM_BIT = 3;
   localparam int FS_INPUT_OVERVOLT_FLAG_BIT = 2;
   localparam int FS_BUSERR_BIT = 1;
   // reset values
   localparam logic [7:0] FAULT_RST = 8'h00;
   localparam logic [7:0] RES_RST = 8'h00;
   // conversion result layout
   localparam int RES_W = 14;
   localparam int RES_CH = 8;
   localparam int RES_HI14_LSB = 6;
   localparam int RES_LO_W = 6;
   // supervisory timer period codes
   localparam logic [1:0] WDOG_OFF = 2'h0;
   localparam logic [1:0] WDOG_X1 = 2'h1;
   localparam logic [1:0] WDOG_X2 = 2'h2;
   localparam logic [1:0] WDOG_X4 = 2'h3;
   // timing
   localparam int TMR_W = 36;
   localparam longint CLK_HZ = 64'd50000000;
   localparam longint LDO_RESTART_MS = 64'd100;
   localparam longint LDO_RESTART_CYCLES = (LDO_RESTART_MS * CLK_HZ + 64'd999) / 64'd1000;
   localparam longint WDOG_BASE_S = 64'd80;
   localparam longint WDOG_BASE_CYCLES = WDOG_BASE_S * CLK_HZ;
endpackage

// [core/fsar_result_store.sv]
// Purpose: holds the latest conversion value of each channel
// Assumes: one write per cycle at most
// Notes: read side is combinational from the stored words
`timescale 1ns/1ps
module fsar_result_store #(
   parameter int NCH = 8,
   parameter int W = 14
) (
   // clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // store carrier
   fsar_res_if.mem m
);
   if (NCH < 1 || NCH > 8 || W != 14) begin : g_chk
      $error("store size does not fit the carrier");
   end

   typedef struct packed {
      logic [NCH-1:0][W-1:0] val;
   } fsar_store_s;

   fsar_store_s s_r;
   fsar_store_s s_nxt;

   always_comb begin
      s_nxt = s_r;
      for (int i = 0; i < NCH; i++) begin
         if (m.wr && (m.wr_ch == 3'(i))) begin
            s_nxt.val[i] = m.wr_val;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign m.rd_val = s_r.val[m.rd_ch];
endmodule

// [core/fsar_timer.sv]
// Purpose: cycle counter for restart hold-off and supervisory timeout
// Assumes: limit of at least one cycle
// Notes: AUTO restarts the count after each expiry
`timescale 1ns/1ps
module fsar_timer #(
   parameter bit AUTO = 1'b0
) (
   // clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // control carrier
   fsar_tmr_if.tmr t
);
   typedef struct packed {
      logic [35:0] cnt;
      logic busy;
      logic done;
   } fsar_tmr_s;

   fsar_tmr_s s_r;
   fsar_tmr_s s_nxt;

   always_comb begin
      s_nxt = s_r;
      s_nxt.done = 1'b0;
      if (!t.run) begin
         s_nxt.cnt = '0;
         s_nxt.busy = 1'b0;
      end else if (t.kick || (AUTO && !s_r.busy)) begin
         s_nxt.cnt = '0;
         s_nxt.busy = 1'b1;
      end else if (s_r.busy) begin
         if (s_r.cnt >= t.limit - 36'h1) begin
            s_nxt.done = 1'b1;
            s_nxt.cnt = '0;
            s_nxt.busy = AUTO;
         end else begin
            s_nxt.cnt = s_r.cnt + 36'h1;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign t.busy = s_r.busy;
   assign t.done = s_r.done;
endmodule

// [core/fsar_top.sv]
// Purpose: fault flag, alert pin and conversion result registers
// Assumes: register strobes from an external serial slave, one cycle each
// Notes: read data is registered on the read strobe edge
`timescale 1ns/1ps
// Behaviour
// (R1) irq_release write frees alert, bit self-clears
// (R2) alert may stay low while fault persists
// (R3) live alert level shown in status bit 6
// (R4) ldo overload latched, cleared by read
// (R5) ldo flag never suppressed by mask
// (R6) ldo read-clear blocked during restart delay
// (R7) thermal flag clears on read once gone
// (R8) switch overcurrent clears on read once gone
// (R9) timeout flag set on expiry, read-proof
// (R10) host read or disable restarts timer
// (R11) hiccup flag set, held through hiccup
// (R12) hiccup flag read-clear only after exit
// (R13) input undervolt clears once input recovers
// (R14) output overvolt clears once output drops
// (R15) low demand flag clears after state left
// (R16) input overvolt latched only when powered on
// (R17) bus error flag on failed command
// (R18) high result byte: 13:6 or 7:0
// (R19) low result byte: bits 5:0, top zero
// (R20) status and result registers reset zero
// (R21) results follow selected read channel
// (R22) timer period off, x1, x2, x4
// (R23) new fault drives alert low
// (R24) writes to read-only bits ignored
module fsar_top #(
   parameter logic [35:0] LDO_DELAY_CYCLES = 36'(fsar_pkg::LDO_RESTART_CYCLES),
   parameter logic [35:0] WDOG_BASE_CYCLES = 36'(fsar_pkg::WDOG_BASE_CYCLES)
) (
   // clock and reset
   input wire logic clk,
   input wire logic sys_rst,

   // register access
   input wire logic [7:0] reg_addr,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,

   // fault conditions
   input wire logic ldo_overcurrent,
   input wire logic ldo_undervolt,
   input wire logic die_overtemp,
   input wire logic switch_overcurrent,
   input wire logic hiccup_state,
   input wire logic input_below_uv,
   input wire logic output_above_ov,
   input wire logic low_demand_off_state,
   input wire logic input_above_ov,
   input wire logic power_on_state,
   input wire logic bus_error_event,

   // supervisory timer
   input wire logic [1:0] wdog_period_sel,

   // conversion results
   input wire logic conv_valid,
   input wire logic [2:0] conv_channel,
   input wire logic [13:0] conv_value,
   input wire logic conv_is_14bit,
   input wire logic [2:0] result_channel_select,

   // alert pin
   input wire logic fault_alert_i,
   output logic fault_alert_o,
   output logic fault_alert_oe_n
);
   // refuse counts the timers cannot serve
   if (LDO_DELAY_CYCLES < 36'h1) begin : g_chk_ldo
      $error("restart hold-off shorter than one cycle");
   end

   if (WDOG_BASE_CYCLES < 36'h1) begin : g_chk_wd_min
      $error("timeout base shorter than one cycle");
   end

   // the longest period is four times the base
   if (WDOG_BASE_CYCLES > 36'h3ffffffff) begin : g_chk_wd_max
      $error("timeout base too large for the longest period");
   end

   if (fsar_pkg::TMR_W != 36) begin : g_chk_tmr_w
      $error("timer width differs from the timer carrier");
   end

   // refuse a result layout the byte split cannot serve
   if (fsar_pkg::RES_W != 14) begin : g_chk_res_w
      $error("result width differs from the store carrier");
   end

   if (fsar_pkg::RES_CH < 1 || fsar_pkg::RES_CH > 8) begin : g_chk_res_ch
      $error("result channel count outside the select range");
   end

   if (fsar_pkg::RES_HI14_LSB + 8 != fsar_pkg::RES_W) begin : g_chk_res_hi
      $error("high result byte does not end at the top bit");
   end

   if (fsar_pkg::RES_LO_W != fsar_pkg::RES_HI14_LSB) begin : g_chk_res_lo
      $error("low result byte does not meet the high byte");
   end

   // refuse field positions outside a byte
   if (fsar_pkg::GS_ALERT_BIT > 7) begin : g_chk_gs
      $error("status field outside the byte");
   end

   if (fsar_pkg::FP_IRQ_RELEASE_BIT > 7 || fsar_pkg::FP_LDO_BIT > 7 ||
       fsar_pkg::FP_THERM_BIT > 7 || fsar_pkg::FP_SWOC_BIT > 7) begin : g_chk_fp
      $error("primary fault field outside the byte");
   end

   if (fsar_pkg::FS_WDOG_BIT > 7 || fsar_pkg::FS_HICCUP_BIT > 7 || fsar_pkg::FS_VIN_UV_BIT > 7 ||
       fsar_pkg::FS_OUTPUT_OVERVOLT_FLAG_BIT > 7 || fsar_pkg::FS_LOWDEM_BIT > 7 ||
       fsar_pkg::FS_INPUT_OVERVOLT_FLAG_BIT > 7 || fsar_pkg::FS_BUSERR_BIT > 7) begin : g_chk_fs
      $error("secondary fault field outside the byte");
   end

   // reset values must read as zero
   if (fsar_pkg::FAULT_RST != 8'h00 || fsar_pkg::RES_RST != 8'h00) begin : g_chk_rst
      $error("register reset values must be zero");
   end

   // register offsets must not overlap
   if (fsar_pkg::REG_FAULT_P == fsar_pkg::REG_FAULT_S || fsar_pkg::REG_RES_HI == fsar_pkg::REG_RES_LO ||
       fsar_pkg::REG_GEN_STATUS == fsar_pkg::REG_FAULT_P) begin : g_chk_reg
      $error("register offsets overlap");
   end

   typedef struct packed {
      logic [7:0] flags_p;
      logic [7:0] flags_s;
      logic [7:0] rdata;
      logic [7:0] res_hi;
      logic [7:0] res_lo;
      logic alert_oe_n;
      logic alert_lvl;
   } fsar_state_s;

   fsar_state_s s_r;
   fsar_state_s s_nxt;

   fsar_tmr_if ldo_t ();
   fsar_tmr_if wdog_t ();
   fsar_res_if res ();

   logic rd_p;
   logic rd_s;
   logic release_req;
   logic [7:0] set_p;
   logic [7:0] set_s;
   logic [7:0] clr_ok_p;
   logic [7:0] clr_ok_s;
   logic any_cond;
   logic new_set;
   logic [13:0] sel_val;
   logic [7:0] hi_byte;
   logic [7:0] lo_byte;
   logic [7:0] flags_p_nxt;
   logic [7:0] flags_s_nxt;

   // restart hold-off after ldo overcurrent
   assign ldo_t.run = 1'b1;
   assign ldo_t.kick = ldo_overcurrent; // R6
   assign ldo_t.limit = LDO_DELAY_CYCLES;

   fsar_timer #(
      .AUTO(1'b0)
   ) u_ldo_tmr (
      .clk(clk),
      .sys_rst(sys_rst),
      .t(ldo_t)
   );

   // supervisory timer
   assign wdog_t.run = (wdog_period_sel != fsar_pkg::WDOG_OFF); // R10 R22
   assign wdog_t.kick = reg_rd; // R10

   always_comb begin
      case (wdog_period_sel)
         fsar_pkg::WDOG_X1: wdog_t.limit = WDOG_BASE_CYCLES; // R22
         fsar_pkg::WDOG_X2: wdog_t.limit = 36'(WDOG_BASE_CYCLES << 1); // R22
         fsar_pkg::WDOG_X4: wdog_t.limit = 36'(WDOG_BASE_CYCLES << 2); // R22
         default: wdog_t.limit = WDOG_BASE_CYCLES;
      endcase
   end

   fsar_timer #(
      .AUTO(1'b1)
   ) u_wdog_tmr (
      .clk(clk),
      .sys_rst(sys_rst),
      .t(wdog_t)
   );

   // per-channel conversion store
   assign res.wr = conv_valid;
   assign res.wr_ch = conv_channel;
   assign res.wr_val = conv_value;
   assign res.rd_ch = result_channel_select; // R21

   fsar_result_store #(
      .NCH(fsar_pkg::RES_CH),
      .W(fsar_pkg::RES_W)
   ) u_store (
      .clk(clk),
      .sys_rst(sys_rst),
      .m(res)
   );

   assign sel_val = res.rd_val;

   // result byte split
   always_comb begin
      if (conv_is_14bit) begin
         hi_byte = sel_val[fsar_pkg::RES_HI14_LSB +: 8]; // R18
         lo_byte = {2'h0, sel_val[fsar_pkg::RES_LO_W-1:0]}; // R19
      end else begin
         hi_byte = sel_val[7:0]; // R18
         lo_byte = 8'h00;
      end
   end

   // access decode
   assign rd_p = reg_rd && (reg_addr == fsar_pkg::REG_FAULT_P);
   assign rd_s = reg_rd && (reg_addr == fsar_pkg::REG_FAULT_S);
   assign release_req = reg_wr && (reg_addr == fsar_pkg::REG_FAULT_P) &&
                        reg_wdata[fsar_pkg::FP_IRQ_RELEASE_BIT]; // R1

   // primary set and clear terms
   always_comb begin
      set_p = 8'h00;
      clr_ok_p = 8'h00;
      set_p[fsar_pkg::FP_LDO_BIT] = ldo_overcurrent | ldo_undervolt; // R4 R5
      clr_ok_p[fsar_pkg::FP_LDO_BIT] = ~ldo_t.busy; // R6
      set_p[fsar_pkg::FP_THERM_BIT] = die_overtemp; // R7
      clr_ok_p[fsar_pkg::FP_THERM_BIT] = ~die_overtemp; // R7
      set_p[fsar_pkg::FP_SWOC_BIT] = switch_overcurrent; // R8
      clr_ok_p[fsar_pkg::FP_SWOC_BIT] = ~switch_overcurrent; // R8
   end

   // secondary set and clear terms
   always_comb begin
      set_s = 8'h00;
      clr_ok_s = 8'h00;
      set_s[fsar_pkg::FS_WDOG_BIT] = wdog_t.done; // R9
      clr_ok_s[fsar_pkg::FS_WDOG_BIT] = 1'b0; // R9
      set_s[fsar_pkg::FS_HICCUP_BIT] = hiccup_state; // R11
      clr_ok_s[fsar_pkg::FS_HICCUP_BIT] = ~hiccup_state; // R12
      set_s[fsar_pkg::FS_VIN_UV_BIT] = input_below_uv; // R13
      clr_ok_s[fsar_pkg::FS_VIN_UV_BIT] = ~input_below_uv; // R13
      set_s[fsar_pkg::FS_OUTPUT_OVERVOLT_FLAG_BIT] = output_above_ov; // R14
      clr_ok_s[fsar_pkg::FS_OUTPUT_OVERVOLT_FLAG_BIT] = ~output_above_ov; // R14
      set_s[fsar_pkg::FS_LOWDEM_BIT] = low_demand_off_state; // R15
      clr_ok_s[fsar_pkg::FS_LOWDEM_BIT] = ~low_demand_off_state; // R15
      set_s[fsar_pkg::FS_INPUT_OVERVOLT_FLAG_BIT] = input_above_ov & power_on_state; // R16
      clr_ok_s[fsar_pkg::FS_INPUT_OVERVOLT_FLAG_BIT] = ~input_above_ov; // R16
      set_s[fsar_pkg::FS_BUSERR_BIT] = bus_error_event; // R17
      clr_ok_s[fsar_pkg::FS_BUSERR_BIT] = 1'b1;
   end

   // alert terms
   assign new_set = |(set_p & ~s_r.flags_p) | |(set_s & ~s_r.flags_s); // R23
   assign any_cond = ldo_overcurrent | ldo_undervolt | die_overtemp | switch_overcurrent |
                     hiccup_state | input_below_uv | output_above_ov | low_demand_off_state |
                     (input_above_ov & power_on_state); // R2

   // latch per bit, set winning over read-clear
   for (genvar b = 0; b < 8; b++) begin : g_flag
      assign flags_p_nxt[b] = set_p[b] | (s_r.flags_p[b] & ~(rd_p & clr_ok_p[b])); // R4 R7 R8
      assign flags_s_nxt[b] = set_s[b] | (s_r.flags_s[b] & ~(rd_s & clr_ok_s[b])); // R9 R12
   end

   always_comb begin
      s_nxt = s_r;
      // flags change only by set and read-clear
      s_nxt.flags_p = flags_p_nxt; // R24
      s_nxt.flags_s = flags_s_nxt; // R24

      // result registers track the selected channel
      s_nxt.res_hi = hi_byte; // R21
      s_nxt.res_lo = lo_byte; // R19

      // alert pin drive
      s_nxt.alert_lvl = 1'b0;
      if (new_set) begin
         s_nxt.alert_oe_n = 1'b0; // R23
      end else if (release_req && !any_cond) begin
         s_nxt.alert_oe_n = 1'b1; // R1 R2
      end

      // registered read data
      if (reg_rd) begin
         case (reg_addr)
            fsar_pkg::REG_GEN_STATUS: begin
               s_nxt.rdata = 8'h00;
               s_nxt.rdata[fsar_pkg::GS_ALERT_BIT] = fault_alert_i; // R3
            end
            fsar_pkg::REG_FAULT_P: begin
               s_nxt.rdata = s_r.flags_p; // R1
            end
            fsar_pkg::REG_FAULT_S: begin
               s_nxt.rdata = s_r.flags_s;
            end
            fsar_pkg::REG_RES_HI: begin
               s_nxt.rdata = s_r.res_hi; // R18
            end
            fsar_pkg::REG_RES_LO: begin
               s_nxt.rdata = s_r.res_lo; // R19
            end
            default: begin
               s_nxt.rdata = 8'h00;
            end
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         s_r.flags_p <= fsar_pkg::FAULT_RST; // R20
         s_r.flags_s <= fsar_pkg::FAULT_RST; // R20
         s_r.rdata <= 8'h00;
         s_r.res_hi <= fsar_pkg::RES_RST; // R20
         s_r.res_lo <= fsar_pkg::RES_RST; // R20
         s_r.alert_oe_n <= 1'b1;
         s_r.alert_lvl <= 1'b0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign reg_rdata = s_r.rdata;
   assign fault_alert_o = s_r.alert_lvl;
   assign fault_alert_oe_n = s_r.alert_oe_n;
endmodule
